//--- hw/cml_cfg.svh
// Addresses, widths, reset values and timing constants of the latch bank
`ifndef CML_CFG_SVH
`define CML_CFG_SVH

// Serial command layout, most significant bit first
`define CML_CMD_BITS 8
`define CML_CMD_CNT_W 3
`define CML_CMD_LAST 3'h7
`define CML_CMD_VALUE_BIT 7
`define CML_CMD_ADDR_HI 6
`define CML_CMD_ADDR_LO 1
`define CML_ADDR_W 6

// Configuration bit addresses held by this bank
`define CML_ADDR_TRIM_LSB 6'h30
`define CML_ADDR_TRIM_MSB 6'h31
`define CML_ADDR_VFAC_LSB 6'h32
`define CML_ADDR_VFAC_MSB 6'h33
`define CML_ADDR_GAIN 6'h34
`define CML_ADDR_TAMPER 6'h35
`define CML_ADDR_STEPPER 6'h36
`define CML_CFG_FIRST 6'h30
`define CML_CFG_LAST 6'h36
`define CML_CFG_W 7

// Bit positions inside the seven-bit configuration vector
`define CML_POS_TRIM_LSB 0
`define CML_POS_TRIM_MSB 1
`define CML_POS_VFAC_LSB 2
`define CML_POS_VFAC_MSB 3
`define CML_POS_GAIN 4
`define CML_POS_TAMPER 5
`define CML_POS_STEPPER 6

// Mode latch addresses
`define CML_ADDR_BOOST 6'h38
`define CML_ADDR_SOURCE 6'h3D
`define CML_ADDR_PERM_WE 6'h3E

// Reset values
`define CML_SHADOW_RST 7'h00
`define CML_MODE_RST 1'h0

// Oscillator trim, percent
`define CML_TRIM_NONE 8'sh00
`define CML_TRIM_UP 8'sh0A
`define CML_TRIM_DOWN -8'sh0A

// Voltage factor constants, scaled by 10000
`define CML_VFAC_0 16'h0E0A
`define CML_VFAC_1 16'h0F42
`define CML_VFAC_2 16'h107B
`define CML_VFAC_3 16'h11B3

// Extra current gain increments
`define CML_GAIN_OFF 4'h0
`define CML_GAIN_ON 4'h8

// Tamper thresholds, hundredths of a percent
`define CML_TAMPER_WIDE 16'h04E2
`define CML_TAMPER_NARROW 16'h0271

// Stepper pulse widths in ns, and the clock period in ns
`define CML_CLK_PERIOD_NS 8
`define CML_STEP_5V_NS 31250000
`define CML_STEP_3V_NS 156250000

`endif

//--- hw/cml_latch_bank.sv
// Configuration field and mode latch bank behind the serial config port
//
// Overview of operation
// - Two-bit oscillator trim: 0 and 3 none, 1 raises 10%, 2 lowers 10%
// - Voltage factor codes 0..3 select 0.3594, 0.3906, 0.4219, 0.4531
// - Extra gain bit at address 52 adds 0 when clear, 8 when set
// - Tamper bit, neutral-monitoring variants: 12.5% clear, 6.25% set
// - Stepper bit: 31.25 ms pulse when clear, 156.25 ms when set
// - Odd address of each two-bit field holds its most significant bit
// - Mode latches are volatile and clear on power-on reset
// - Mode latches use the same addressed single-bit write command
// - Boost mode set turns motor outputs into charge-pump drive
// - Source select clear uses anti-fuses, set uses shadow latches
// - Permanent write enable set also programs the anti-fuse element
// - Source select set disconnects every sense amplifier
// - Command byte: value, six-bit address, don't-care bit, MSB first
// - Last command bit's serial clock pulse makes the latch strobe
`timescale 1ns/1ps
`include "cml_cfg.svh"

module cml_latch_bank
    import cml_pkg::*;
#(
    parameter bit HAS_RC_OSC = 1'b1,
    parameter bit HAS_NEUTRAL = 1'b1,
    parameter int unsigned STEP_5V_CYCLES =
        `CML_STEP_5V_NS / `CML_CLK_PERIOD_NS,
    parameter int unsigned STEP_3V_CYCLES =
        `CML_STEP_3V_NS / `CML_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic config_select_n,
    input wire logic config_sync_line,
    input wire logic config_serial_clock,
    input wire logic config_serial_data,
    input wire logic [`CML_CFG_W-1:0] fuse_bits,
    input wire logic motor_drive_pos,
    input wire logic motor_drive_neg,
    input wire logic pump_phase,
    output logic motor_out_pos,
    output logic motor_out_neg,
    output logic boost_drive_mode,
    output logic config_source_select,
    output logic permanent_write_enable,
    output logic sense_amp_connect,
    output logic fuse_program_pulse,
    output logic [`CML_ADDR_W-1:0] fuse_program_addr,
    output logic fuse_program_value,
    output logic [`CML_CFG_W-1:0] shadow_bits,
    output logic [1:0] osc_trim_field,
    output logic signed [7:0] osc_trim_percent,
    output logic [1:0] rated_voltage_factor,
    output logic [15:0] voltage_factor_constant,
    output logic [3:0] extra_current_gain,
    output logic [15:0] tamper_threshold,
    output logic stepper_type,
    output logic [31:0] stepper_pulse_cycles,
    output logic bad_address_seen
);

    // Decoding helpers; only the two address tests are used by more than one output path
    function automatic logic signed [7:0] trim_percent(input logic [1:0] c);
        case (c)
            2'h1: trim_percent = `CML_TRIM_UP;
            2'h2: trim_percent = `CML_TRIM_DOWN;
            default: trim_percent = `CML_TRIM_NONE;
        endcase
    endfunction

    function automatic logic [15:0] vfac_const(input logic [1:0] c);
        case (c)
            2'h0: vfac_const = `CML_VFAC_0;
            2'h1: vfac_const = `CML_VFAC_1;
            2'h2: vfac_const = `CML_VFAC_2;
            default: vfac_const = `CML_VFAC_3;
        endcase
    endfunction

    function automatic logic is_cfg_addr(input cml_addr_t a);
        is_cfg_addr = (a >= `CML_CFG_FIRST) && (a <= `CML_CFG_LAST);
    endfunction

    function automatic logic is_mode_addr(input cml_addr_t a);
        is_mode_addr = (a == `CML_ADDR_BOOST) || (a == `CML_ADDR_SOURCE)
            || (a == `CML_ADDR_PERM_WE);
    endfunction

    // Serial port pins and fuse bits cross into clk through two flops before any use
    logic [3:0] pins_raw;
    logic [3:0] pins_s;
    logic [`CML_CFG_W-1:0] fuse_s;

    assign pins_raw = {config_select_n, config_sync_line,
        config_serial_clock, config_serial_data};

    cml_sync2 #(
        .WIDTH(4),
        .RST_VAL(4'hF)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    cml_sync2 #(
        .WIDTH(`CML_CFG_W),
        .RST_VAL(`CML_SHADOW_RST)
    ) u_fuse_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(fuse_bits),
        .sync_out(fuse_s)
    );

    wire select_n_s = pins_s[3];
    wire sync_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire sdata_s = pins_s[0];

    // Serial receiver
    logic sclk_prev_q;
    logic [`CML_CMD_CNT_W-1:0] bit_cnt_q;
    logic [`CML_CMD_CNT_W-1:0] bit_cnt_d;
    cml_cmd_t shift_q;
    cml_cmd_t shift_d;
    cml_rx_state_e state_q;
    cml_rx_state_e state_d;

    // Both select and sync must be low; otherwise framing restarts
    wire frame_active = !select_n_s && !sync_s;
    // Idle-high clock: its falling edge is the leading, sampling edge
    wire lead_edge = sclk_prev_q && !sclk_s;
    wire last_bit = (bit_cnt_q == `CML_CMD_LAST);
    wire take_bit = frame_active && lead_edge;
    // Strobe from the final serial clock pulse, not a free-running clock
    wire strobe = take_bit && last_bit;

    // Shift in MSB first; value then address, last bit ignored
    assign shift_d = take_bit ? {shift_q[6:0], sdata_s} : shift_q;

    // The command as it stands once the final bit is shifted in
    wire cml_cmd_t cmd_full = shift_d;
    wire cmd_value = cmd_full[`CML_CMD_VALUE_BIT];
    wire cml_addr_t cmd_addr =
        cmd_full[`CML_CMD_ADDR_HI:`CML_CMD_ADDR_LO];

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        case (state_q)
            CML_IDLE: begin
                bit_cnt_d = '0;
                if (frame_active) begin
                    state_d = CML_SHIFT;
                end
            end
            CML_SHIFT: begin
                if (!frame_active) begin
                    state_d = CML_IDLE;
                    bit_cnt_d = '0;
                end else if (strobe) begin
                    state_d = CML_DONE;
                    bit_cnt_d = '0;
                end else if (take_bit) begin
                    bit_cnt_d = bit_cnt_q + 3'h1;
                end
            end
            CML_DONE: begin
                // A string of commands may follow in the same frame
                state_d = frame_active ? CML_SHIFT : CML_IDLE;
                bit_cnt_d = '0;
            end
            default: begin
                state_d = CML_IDLE;
                bit_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= CML_IDLE;
            bit_cnt_q <= '0;
            shift_q <= '0;
            sclk_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            sclk_prev_q <= sclk_s;
        end
    end

    // Write decode
    wire cfg_hit = strobe && is_cfg_addr(cmd_addr);
    wire mode_hit = strobe && is_mode_addr(cmd_addr);
    wire miss = strobe && !is_cfg_addr(cmd_addr)
        && !is_mode_addr(cmd_addr);
    wire [2:0] cfg_idx = 3'(cmd_addr - `CML_CFG_FIRST);

    // Shadow latches
    logic [`CML_CFG_W-1:0] shadow_q;
    logic [`CML_CFG_W-1:0] shadow_d;

    always_comb begin
        shadow_d = shadow_q;
        if (cfg_hit) begin
            shadow_d[cfg_idx] = cmd_value;
        end
    end

    // Mode latches, written through the same command
    logic boost_q;
    logic source_q;
    logic perm_we_q;
    wire boost_d = (mode_hit && cmd_addr == `CML_ADDR_BOOST)
        ? cmd_value : boost_q;
    wire source_d = (mode_hit && cmd_addr == `CML_ADDR_SOURCE)
        ? cmd_value : source_q;
    wire perm_we_d = (mode_hit && cmd_addr == `CML_ADDR_PERM_WE)
        ? cmd_value : perm_we_q;

    // Anti-fuse programming only when permanent write is enabled
    wire fuse_pulse_d = cfg_hit && perm_we_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // Volatile state: power-on reset always clears it
            boost_q <= `CML_MODE_RST;
            source_q <= `CML_MODE_RST;
            perm_we_q <= `CML_MODE_RST;
            shadow_q <= `CML_SHADOW_RST;
        end else begin
            boost_q <= boost_d;
            source_q <= source_d;
            perm_we_q <= perm_we_d;
            shadow_q <= shadow_d;
        end
    end

    // Effective configuration, from shadow or anti-fuse
    wire [`CML_CFG_W-1:0] eff_bits = source_q ? shadow_q : fuse_s;

    // Odd address is the field's MSB
    wire [1:0] trim_raw = {eff_bits[`CML_POS_TRIM_MSB],
        eff_bits[`CML_POS_TRIM_LSB]};
    wire [1:0] vfac_raw = {eff_bits[`CML_POS_VFAC_MSB],
        eff_bits[`CML_POS_VFAC_LSB]};
    // Crystal variants have no trim; field reads as no adjustment
    wire [1:0] trim_code = HAS_RC_OSC ? trim_raw : 2'h0;
    // Tamper bit only acts where neutral is monitored
    wire tamper_bit = HAS_NEUTRAL ? eff_bits[`CML_POS_TAMPER] : 1'b0;
    wire gain_bit = eff_bits[`CML_POS_GAIN];
    wire step_bit = eff_bits[`CML_POS_STEPPER];

    // Motor pins follow the drive or the pump phase pair
    wire mot_pos_d = boost_q ? pump_phase : motor_drive_pos;
    wire mot_neg_d = boost_q ? !pump_phase : motor_drive_neg;

    // Registered outputs
    logic mot_pos_q;
    logic mot_neg_q;
    logic fuse_pulse_q;
    logic [`CML_ADDR_W-1:0] fuse_addr_q;
    logic fuse_value_q;
    logic [1:0] trim_q;
    logic signed [7:0] trim_pct_q;
    logic [1:0] vfac_q;
    logic [15:0] vconst_q;
    logic [3:0] gain_q;
    logic [15:0] tamper_q;
    logic step_q;
    logic [31:0] step_cyc_q;
    logic bad_addr_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mot_pos_q <= 1'b0;
            mot_neg_q <= 1'b0;
            fuse_pulse_q <= 1'b0;
            fuse_addr_q <= '0;
            fuse_value_q <= 1'b0;
            bad_addr_q <= 1'b0;
        end else begin
            mot_pos_q <= mot_pos_d;
            mot_neg_q <= mot_neg_d;
            fuse_pulse_q <= fuse_pulse_d;
            if (fuse_pulse_d) begin
                fuse_addr_q <= cmd_addr;
                fuse_value_q <= cmd_value;
            end
            // Sticky until the next power-on reset; diagnostic only
            bad_addr_q <= bad_addr_q || miss;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trim_q <= 2'h0;
            trim_pct_q <= `CML_TRIM_NONE;
            vfac_q <= 2'h0;
            vconst_q <= `CML_VFAC_0;
            gain_q <= `CML_GAIN_OFF;
            tamper_q <= `CML_TAMPER_WIDE;
            step_q <= 1'b0;
            step_cyc_q <= STEP_5V_CYCLES;
        end else begin
            trim_q <= trim_code;
            trim_pct_q <= trim_percent(trim_code);
            vfac_q <= vfac_raw;
            vconst_q <= vfac_const(vfac_raw);
            gain_q <= gain_bit ? `CML_GAIN_ON : `CML_GAIN_OFF;
            tamper_q <= tamper_bit ? `CML_TAMPER_NARROW
                : `CML_TAMPER_WIDE;
            step_q <= step_bit;
            step_cyc_q <= step_bit ? STEP_3V_CYCLES
                : STEP_5V_CYCLES;
        end
    end

    assign motor_out_pos = mot_pos_q;
    assign motor_out_neg = mot_neg_q;
    assign boost_drive_mode = boost_q;
    assign config_source_select = source_q;
    assign permanent_write_enable = perm_we_q;
    // Keeps low-voltage sense gates off the program supply
    assign sense_amp_connect = !source_q;
    assign fuse_program_pulse = fuse_pulse_q;
    assign fuse_program_addr = fuse_addr_q;
    assign fuse_program_value = fuse_value_q;
    assign shadow_bits = shadow_q;
    assign osc_trim_field = trim_q;
    assign osc_trim_percent = trim_pct_q;
    assign rated_voltage_factor = vfac_q;
    assign voltage_factor_constant = vconst_q;
    assign extra_current_gain = gain_q;
    assign tamper_threshold = tamper_q;
    assign stepper_type = step_q;
    assign stepper_pulse_cycles = step_cyc_q;
    assign bad_address_seen = bad_addr_q;

endmodule // cml_latch_bank

//--- hw/cml_pkg.sv
// Types shared by the configuration and mode latch bank
package cml_pkg;

    typedef enum logic [1:0] {
        CML_IDLE = 2'b00,
        CML_SHIFT = 2'b01,
        CML_DONE = 2'b10
    } cml_rx_state_e;

    typedef logic [5:0] cml_addr_t;

    typedef logic [7:0] cml_cmd_t;

endpackage

//--- hw/cml_sync2.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/1ps

module cml_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // cml_sync2

//--- tb/cml_host_model.sv
// Host side of the serial configuration port
`timescale 1ns/1ps

module cml_host_model
    import cml_pkg::*;
(
    input wire logic clk,
    output logic config_select_n,
    output logic config_sync_line,
    output logic config_serial_clock,
    output logic config_serial_data
);
    // Programming supply level, high while above the 3 V mark
    logic program_supply_hi = 1'b0;
    // Pins have pull-ups, so released lines sit high
    initial begin
        {config_select_n, config_sync_line} = 2'h3;
        {config_serial_clock, config_serial_data} = 2'h3;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Decay after switch-off is a fixed wait
    task automatic set_supply(input logic on);
        if (!on) gap(16);
        program_supply_hi = on;
        gap(1);
    endtask
    task automatic open_frame();
        config_select_n = 1'b0;
        config_sync_line = 1'b0;
        gap(4);
    endtask
    // Data moves only while the serial clock is high
    task automatic send(input cml_cmd_t cmd, input int nbits, input int half);
        // Clearing source select waits for the supply to decay
        if (cmd[7:1] == 7'h3D) wait (!program_supply_hi);
        for (int i = 7; i > 7 - nbits; i--) begin
            config_serial_data = cmd[i];
            gap(half);
            config_serial_clock = 1'b0;
            gap(half);
            config_serial_clock = 1'b1;
        end
    endtask
    task automatic close_frame();
        gap(4);
        {config_select_n, config_sync_line} = 2'h3;
        config_serial_data = 1'b1;
    endtask
endmodule // cml_host_model

//--- tb/cml_latch_bank_properties.sv
// Port-level checks for the configuration and mode latch bank
`timescale 1ns/1ps

module cml_latch_bank_properties #(
    parameter int unsigned STEP_5V_CYCLES = 50,
    parameter int unsigned STEP_3V_CYCLES = 250
) (
    input logic clk,
    input logic sys_rst,
    input logic pump_phase,
    input logic motor_out_pos,
    input logic motor_out_neg,
    input logic boost_drive_mode,
    input logic config_source_select,
    input logic permanent_write_enable,
    input logic sense_amp_connect,
    input logic fuse_program_pulse,
    input logic [5:0] fuse_program_addr,
    input logic fuse_program_value,
    input logic [6:0] shadow_bits,
    input logic [1:0] osc_trim_field,
    input logic signed [7:0] osc_trim_percent,
    input logic [1:0] rated_voltage_factor,
    input logic [15:0] voltage_factor_constant,
    input logic [3:0] extra_current_gain,
    input logic [15:0] tamper_threshold,
    input logic stepper_type,
    input logic [31:0] stepper_pulse_cycles,
    input logic bad_address_seen
);
    localparam logic [15:0] VF [4] =
        '{16'h0E0A, 16'h0F42, 16'h107B, 16'h11B3};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Decode lags the shadow latches by one cycle
    sequence s_shadow_view;
        config_source_select [*3];
    endsequence
    sequence s_store_still;
        $stable(shadow_bits) && $stable({boost_drive_mode,
            config_source_select, permanent_write_enable});
    endsequence

    property p_rst_clear;
        $fell(sys_rst) |-> !boost_drive_mode && !config_source_select
            && !permanent_write_enable;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("mode latch set after reset");
    property p_sense;
        sense_amp_connect == !config_source_select;
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense amplifier link wrong");
    property p_trim;
        osc_trim_percent == (osc_trim_field == 2'h1 ? 8'sh0A :
            osc_trim_field == 2'h2 ? -8'sh0A : 8'sh00);
    endproperty
    a_trim: assert property (p_trim)
        else $error("trim percent wrong");
    property p_vfac;
        voltage_factor_constant == VF[rated_voltage_factor];
    endproperty
    a_vfac: assert property (p_vfac)
        else $error("voltage factor wrong");
    property p_order;
        s_shadow_view |-> {osc_trim_field, rated_voltage_factor} ==
            {$past(shadow_bits[1:0]), $past(shadow_bits[3:2])};
    endproperty
    a_order: assert property (p_order)
        else $error("field bit order wrong");
    property p_gain;
        s_shadow_view |->
            extra_current_gain == ($past(shadow_bits[4]) ? 4'h8 : 4'h0);
    endproperty
    a_gain: assert property (p_gain)
        else $error("extra gain wrong");
    property p_tamper;
        s_shadow_view |->
            tamper_threshold == ($past(shadow_bits[5]) ? 16'h0271 : 16'h04E2);
    endproperty
    a_tamper: assert property (p_tamper)
        else $error("tamper threshold wrong");
    property p_step;
        s_shadow_view |-> stepper_type == $past(shadow_bits[6]) &&
            stepper_pulse_cycles ==
            (stepper_type ? STEP_3V_CYCLES : STEP_5V_CYCLES);
    endproperty
    a_step: assert property (p_step)
        else $error("stepper pulse wrong");
    property p_motor;
        boost_drive_mode && $past(boost_drive_mode) |->
            motor_out_pos == $past(pump_phase) &&
            motor_out_neg == !$past(pump_phase);
    endproperty
    a_motor: assert property (p_motor)
        else $error("pump drive wrong");
    property p_fuse;
        fuse_program_pulse |-> permanent_write_enable &&
            fuse_program_addr inside {[6'h30:6'h36]} && fuse_program_value
            == shadow_bits[fuse_program_addr - 6'h30] ##1 !fuse_program_pulse;
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("fuse program pulse wrong");
    property p_bad;
        $rose(bad_address_seen) |-> s_store_still ##1 bad_address_seen;
    endproperty
    a_bad: assert property (p_bad)
        else $error("unmapped write changed a latch");
endmodule // cml_latch_bank_properties

bind cml_latch_bank cml_latch_bank_properties #(
    .STEP_5V_CYCLES(STEP_5V_CYCLES),
    .STEP_3V_CYCLES(STEP_3V_CYCLES)
) cml_latch_bank_properties_i (.*);

//--- tb/tb.sv
// Self-checking bench for the configuration and mode latch bank
`timescale 1ns/1ps

module tb;
    import cml_pkg::*;
    localparam logic [31:0] S5 = 32'h32;
    localparam logic [31:0] S3 = 32'hFA;
    localparam logic [15:0] VF [4] =
        '{16'h0E0A, 16'h0F42, 16'h107B, 16'h11B3};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [6:0] fuse_bits = 7'h00;
    logic motor_drive_pos = 1'b0;
    logic motor_drive_neg = 1'b0;
    logic pump_phase = 1'b0;
    logic chk_now = 1'b0;
    wire config_select_n, config_sync_line;
    wire config_serial_clock, config_serial_data;
    wire motor_out_pos, motor_out_neg, boost_drive_mode;
    wire config_source_select, permanent_write_enable, sense_amp_connect;
    wire fuse_program_pulse, fuse_program_value, stepper_type;
    wire bad_address_seen;
    wire [5:0] fuse_program_addr;
    wire [6:0] shadow_bits;
    wire [1:0] osc_trim_field, rated_voltage_factor;
    wire signed [7:0] osc_trim_percent;
    wire [15:0] voltage_factor_constant, tamper_threshold;
    wire [3:0] extra_current_gain;
    wire [31:0] stepper_pulse_cycles;
    wire [94:0] got = {shadow_bits, boost_drive_mode, config_source_select,
        permanent_write_enable, sense_amp_connect, osc_trim_field,
        osc_trim_percent, rated_voltage_factor, voltage_factor_constant,
        extra_current_gain, tamper_threshold, stepper_type,
        stepper_pulse_cycles, motor_out_pos, motor_out_neg, bad_address_seen};
    logic [6:0] sh, fe;
    logic bst, src, we, bad;
    logic [94:0] st_q[$];
    logic [6:0] fz_q[$];
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    cml_latch_bank #(.STEP_5V_CYCLES(S5), .STEP_3V_CYCLES(S3))
        cml_latch_bank_i (.*);
    cml_host_model cml_host_model_i (.*);

    task automatic give_verdict();
        $display("Checked %0d, wrong %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp_state(input logic [94:0] g, input logic [94:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_fuse(input logic [6:0] g, input logic [6:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [94:0] exp_state();
        logic [6:0] b;
        b = src ? sh : fuse_bits;
        return {sh, bst, src, we, !src, b[1:0],
            b[1:0] == 2'h1 ? 8'h0A : b[1:0] == 2'h2 ? 8'hF6 : 8'h00,
            b[3:2], VF[b[3:2]], b[4] ? 4'h8 : 4'h0,
            b[5] ? 16'h0271 : 16'h04E2, b[6], b[6] ? S3 : S5,
            bst ? pump_phase : motor_drive_pos,
            bst ? !pump_phase : motor_drive_neg, bad};
    endfunction
    task automatic note(input logic v, input logic [5:0] a);
        if (a >= 6'h30 && a <= 6'h36) begin
            sh[a - 6'h30] = v;
            if (we) fz_q.push_back({a, v});
        end else if (a == 6'h38) bst = v;
        else if (a == 6'h3D) src = v;
        else if (a == 6'h3E) we = v;
        else bad = 1'b1;
    endtask
    task automatic check();
        repeat (8) @(posedge clk);
        #1;
        st_q.push_back(exp_state());
        chk_now = 1'b1;
        @(posedge clk);
        #1;
        chk_now = 1'b0;
    endtask
    task automatic wr(input logic v, input logic [5:0] a);
        {motor_drive_pos, motor_drive_neg, pump_phase} = 3'($urandom);
        note(v, a);
        cml_host_model_i.open_frame();
        cml_host_model_i.send({v, a, 1'($urandom)}, 8, 3 + $urandom % 6);
        cml_host_model_i.close_frame();
        check();
    endtask
    task automatic do_rst();
        sys_rst = 1'b1;
        fuse_bits = 7'($urandom);
        {sh, bst, src, we, bad} = 11'h000;
        repeat (5) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        check();
    endtask

    always @(posedge clk) begin
        if (chk_now) cmp_state(got, st_q.pop_front());
        fe = fz_q.size() > 0 ? fz_q[0] : 7'h7F;
        if (fz_q.size() > 0 && fuse_program_pulse) fz_q.pop_front();
        if (fuse_program_pulse) cmp_fuse({fuse_program_addr,
            fuse_program_value}, fe);
    end
    // Ceiling sits well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h8F54));
        do_rst();
        for (int i = 0; i < 7; i++) wr(1'($urandom), 6'h30 + 6'(i));
        wr(1'b1, 6'h3D);
        for (int c = 0; c < 4; c++) begin
            wr(c[1], 6'h31);
            wr(c[0], 6'h30);
            wr(c[1], 6'h33);
            wr(c[0], 6'h32);
            wr(c[0], 6'h34);
            wr(c[1], 6'h35);
            wr(c[0] ^ c[1], 6'h36);
        end
        wr(1'b1, 6'h38);
        wr(1'b1, 6'h38);
        wr(1'b0, 6'h38);
        cml_host_model_i.set_supply(1'b1);
        wr(1'b1, 6'h3E);
        for (int i = 0; i < 7; i++) wr(1'($urandom), 6'h30 + 6'(i));
        wr(1'b0, 6'h38);
        wr(1'b0, 6'h3E);
        cml_host_model_i.set_supply(1'b0);
        wr(1'b1, 6'h31);
        wr(1'b1, 6'h37);
        wr(1'b1, 6'h3F);
        wr(1'b0, 6'h3D);
        note(1'b1, 6'h38);
        note(1'b0, 6'h34);
        cml_host_model_i.open_frame();
        cml_host_model_i.send(8'hF0, 8, 3);
        cml_host_model_i.send(8'h69, 8, 4);
        // Cut short, so source select must stay clear
        cml_host_model_i.send(8'hFA, 5, 3);
        cml_host_model_i.close_frame();
        check();
        wr(1'b1, 6'h3E);
        do_rst();
        wr(1'b1, 6'h3D);
        cmp_fuse(7'(fz_q.size()), 7'h00);
        give_verdict();
    end
endmodule // tb
